// >>> rtl/wwd_pkg.sv
`default_nettype none
package wwd_pkg;
	// counter width for oscillator ticks
	localparam int unsigned WWD_CW = 24;
	// main clock period in ns
	localparam int unsigned WWD_CLK_NS = 8;
	// power-good deglitch time, typical, in us
	localparam int unsigned WWD_DEGLITCH_US = 180;
	localparam int unsigned WWD_DEGLITCH_CYC = (WWD_DEGLITCH_US * 1000) / WWD_CLK_NS;
	// fixed power-good delay with no capacitor, typical, in us
	localparam int unsigned WWD_DLY_FIX_US = 248;
	localparam int unsigned WWD_DLY_FIX_CYC = (WWD_DLY_FIX_US * 1000) / WWD_CLK_NS;
	// capacitor-set power-good delay, typical, in ms
	localparam int unsigned WWD_DLY_CAP_MS = 20;
	localparam int unsigned WWD_DLY_CAP_CYC = (WWD_DLY_CAP_MS * 1000000) / WWD_CLK_NS;
	// minimum service pulse width in us
	localparam int unsigned WWD_SVC_MIN_US = 100;
	// period scale: low select gives 1x, high select 5x
	localparam int unsigned WWD_SCALE_LO = 1;
	localparam int unsigned WWD_SCALE_HI = 5;
	// initialization window in periods
	localparam int unsigned WWD_INIT_PERIODS = 8;
	// ratio 8:1 means period split into nine slots
	localparam int unsigned WWD_RATIO_SLOTS = 9;
	localparam int unsigned WWD_RATIO_OPEN = 8;
	// fault hold is one fifth of period
	localparam int unsigned WWD_HOLD_DIV = 5;
	// watchdog states
	typedef enum logic [2:0] {
		WWD_OFF,
		WWD_INIT,
		WWD_CLOSED,
		WWD_OPEN
	} wwd_state_t;
endpackage
`default_nettype wire

// >>> rtl/wwd_core.sv
`default_nettype none
// Functional notes
// RULE_01: good rises only after full delay
// RULE_02: good falls after deglitch interval
// RULE_03: no capacitor selects fixed delay
// RULE_04: undervoltage shuts output, restart full sequence
// RULE_05: thermal trip off, on after clear
// RULE_06: type pin low selects window mode
// RULE_07: scale pin high makes period fivefold
// RULE_08: period set by resistor oscillator
// RULE_09: period accuracy within ten percent
// RULE_10: first open window is eight periods
// RULE_11: closed plus open equals period
// RULE_12: ratio low gives half and half
// RULE_13: ratio high gives open eight ninths
// RULE_14: controller services during init window
// RULE_15: service in closed window is fault
// RULE_16: open window ending unserviced is fault
// RULE_17: faults reported on fault pin
// RULE_18: fault pulls pin low fifth period
// RULE_19: controller holds service high 100 us
// RULE_20: enable low arms watchdog when good
// RULE_21: valid service restarts, begins closed window
// RULE_22: all windows counted in oscillator ticks
// RULE_23: service input synchronized, rising edge used
module wwd_core
	import wwd_pkg::*;
#(
	parameter int unsigned DLY_FIX_CYC = WWD_DLY_FIX_CYC,   // fixed good delay
	parameter int unsigned DLY_CAP_CYC = WWD_DLY_CAP_CYC,   // capacitor good delay
	parameter int unsigned DEGLITCH_CYC = WWD_DEGLITCH_CYC, // falling deglitch
	parameter int unsigned OSC_DIV = 125,                   // clk cycles per osc tick
	parameter int unsigned SVC_MIN_TICKS = 2                // ticks service stays high
)
(
	input  wire logic        clk_i,                  // 125 MHz clock
	input  wire logic        rst_i,                  // power-up reset
	input  wire logic        vout_above_rise_i,      // output above rising threshold
	input  wire logic        vout_below_fall_i,      // output below falling threshold
	input  wire logic        delay_cap_present_i,    // capacitor on delay pin
	input  wire logic        input_undervoltage_lock_i, // input supply too low
	input  wire logic        thermal_trip_i,         // trip with hysteresis
	input  wire logic        type_select_pin_i,      // low: window mode
	input  wire logic        period_scale_select_i,  // high: 5x period
	input  wire logic        ratio_select_i,         // high: 8:1 ratio
	input  wire logic [15:0] timing_resistor_pin_i,  // resistor in ohms/100
	input  wire logic        service_in_i,           // async service pulse
	input  wire logic        guard_enable_n_i,       // low enables watchdog
	output logic             output_on_o,            // regulator output enabled
	output logic             supply_good_out_o,      // good level (open drain value)
	output logic             supply_good_out_oe_o,   // good pull-low enable
	output logic             fault_out_n_o,          // fault level
	output logic             fault_out_n_oe_o        // fault pull-low enable
);
	// regulator output state
	logic                   out_on_q;
	// good delay and deglitch counters
	logic [WWD_CW-1:0]      gd_cnt_q;
	logic                   good_q;
	// oscillator divider
	logic [15:0]            osc_cnt_q;
	logic                   tick;
	// period in ticks, derived from resistor
	logic [WWD_CW-1:0]      period_ticks;
	logic [WWD_CW-1:0]      closed_ticks;
	logic [WWD_CW-1:0]      open_ticks;
	logic [WWD_CW-1:0]      hold_ticks;
	logic [WWD_CW+3:0]      init_ticks;
	// open window limit in ticks, by mode
	logic [WWD_CW+3:0]      open_lim;
	// service synchroniser and filter
	logic                   svc_s1_q;
	logic                   svc_s2_q;
	logic [7:0]             svc_hi_q;
	logic                   svc_valid_q;
	logic                   svc_evt;
	// watchdog state
	wwd_state_t             st_q;
	logic [WWD_CW+3:0]      win_q;
	logic [WWD_CW-1:0]      hold_q;
	logic                   enable_lvl;
	logic                   en_q;
	logic                   fault_evt;
	logic                   hold_end_q;

	// output on when input ok and no thermal trip
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			out_on_q <= 1'b0;
		else
			out_on_q <= !input_undervoltage_lock_i && !thermal_trip_i; // RULE_04 RULE_05
	end

	// good qualification: delay on rise, deglitch on fall
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			gd_cnt_q <= '0;
			good_q   <= 1'b0;
		end
		else if (!out_on_q)
		begin
			// shutdown restarts the whole sequence
			gd_cnt_q <= '0; // RULE_04
			good_q   <= 1'b0;
		end
		else if (!good_q)
		begin
			// wait for the full delay above threshold
			if (!vout_above_rise_i)
				gd_cnt_q <= '0;
			else if (delay_cap_present_i ? (gd_cnt_q >= WWD_CW'(DLY_CAP_CYC - 1))
			                             : (gd_cnt_q >= WWD_CW'(DLY_FIX_CYC - 1))) // RULE_03
			begin
				good_q   <= 1'b1; // RULE_01
				gd_cnt_q <= '0;
			end
			else
				gd_cnt_q <= gd_cnt_q + 1'b1;
		end
		else
		begin
			// deglitch before dropping good
			if (!vout_below_fall_i)
				gd_cnt_q <= '0;
			else if (gd_cnt_q >= WWD_CW'(DEGLITCH_CYC - 1))
			begin
				good_q   <= 1'b0; // RULE_02
				gd_cnt_q <= '0;
			end
			else
				gd_cnt_q <= gd_cnt_q + 1'b1;
		end
	end

	// oscillator tick enable
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			osc_cnt_q <= '0;
		// wrap once per tick
		else if (osc_cnt_q >= 16'(OSC_DIV - 1))
			osc_cnt_q <= '0;
		else
			osc_cnt_q <= osc_cnt_q + 1'b1;
	end
	assign tick = (osc_cnt_q >= 16'(OSC_DIV - 1)); // RULE_22

	// period: 50 ticks per hundred ohms, scaled; resistor in hundreds of ohms
	always_comb
	begin
		period_ticks = period_scale_select_i
			? WWD_CW'(timing_resistor_pin_i * 8'd50 * WWD_SCALE_HI)
			: WWD_CW'(timing_resistor_pin_i * 8'd50 * WWD_SCALE_LO); // RULE_07 RULE_08 RULE_09
		// open part: half, or eight ninths
		open_ticks   = ratio_select_i
			? WWD_CW'((period_ticks * WWD_RATIO_OPEN) / WWD_RATIO_SLOTS)
			: WWD_CW'(period_ticks >> 1); // RULE_12 RULE_13
		closed_ticks = period_ticks - open_ticks; // RULE_11
		hold_ticks   = WWD_CW'(period_ticks / WWD_HOLD_DIV);
		init_ticks   = (WWD_CW+4)'(period_ticks) * (WWD_CW+4)'(WWD_INIT_PERIODS); // RULE_10
		// standard mode keeps the whole period open
		open_lim     = (WWD_CW+4)'(type_select_pin_i ? period_ticks : open_ticks); // RULE_06
	end

	// service synchroniser
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			svc_s1_q <= 1'b0;
			svc_s2_q <= 1'b0;
		end
		else
		begin
			svc_s1_q <= service_in_i; // RULE_23
			// first stage is read only by the second
			svc_s2_q <= svc_s1_q;
		end
	end

	// width qualification in ticks, pulse once when long enough
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			svc_hi_q    <= '0;
			svc_valid_q <= 1'b0;
		end
		// service low clears qualification
		else if (!svc_s2_q)
		begin
			svc_hi_q    <= '0;
			svc_valid_q <= 1'b0;
		end
		else if (tick && !svc_valid_q)
		begin
			// count ticks while held high
			if (svc_hi_q >= 8'(SVC_MIN_TICKS - 1))
				svc_valid_q <= 1'b1; // RULE_19 RULE_23
			else
				svc_hi_q <= svc_hi_q + 1'b1;
		end
	end
	assign svc_evt = tick && svc_s2_q && !svc_valid_q && (svc_hi_q >= 8'(SVC_MIN_TICKS - 1));

	// watchdog armed while good and enable low
	assign enable_lvl = good_q && !guard_enable_n_i; // RULE_20

	// enable history for initialization edge
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			en_q <= 1'b0;
		else
			en_q <= enable_lvl;
	end

	// fault cause: closed service or open timeout
	always_comb
	begin
		fault_evt = 1'b0;
		if (tick)
		begin
			case (st_q)
				// service in closed window
				WWD_CLOSED:
					fault_evt = svc_evt; // RULE_15
				// init window ran out unserviced
				WWD_INIT:
					fault_evt = !svc_evt && (win_q >= init_ticks - 1'b1); // RULE_16
				// open window ran out unserviced
				WWD_OPEN:
					fault_evt = !svc_evt && (win_q >= open_lim - 1'b1); // RULE_16
				default:
					fault_evt = 1'b0;
			endcase
		end
	end

	// watchdog window sequencer
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_q <= WWD_OFF;
			win_q <= '0;
		end
		else if (!enable_lvl)
		begin
			st_q  <= WWD_OFF; // RULE_20
			win_q <= '0;
		end
		else if (!en_q || hold_end_q)
		begin
			// rising enable or fault release restarts init
			st_q  <= WWD_INIT; // RULE_10
			win_q <= '0;
		end
		else if (tick)
		begin
			case (st_q)
				// wait for service, or time out
				WWD_INIT, WWD_OPEN:
				begin
					if (svc_evt)
					begin
						// service restarts counter; standard mode opens again
						st_q  <= type_select_pin_i ? WWD_OPEN : WWD_CLOSED; // RULE_06 RULE_21
						win_q <= '0;
					end
					else if (fault_evt)
					begin
						st_q  <= WWD_OFF;
						win_q <= '0;
					end
					else
						win_q <= win_q + 1'b1;
				end
				// early service faults, else open next
				WWD_CLOSED:
				begin
					if (fault_evt)
					begin
						st_q  <= WWD_OFF;
						win_q <= '0;
					end
					else if (win_q >= (WWD_CW+4)'(closed_ticks) - 1'b1)
					begin
						// closed part over, open window begins
						st_q  <= WWD_OPEN; // RULE_11
						win_q <= '0;
					end
					else
						win_q <= win_q + 1'b1;
				end
				// off state idles until restart
				default:
					win_q <= '0;
			endcase
		end
	end

	// fault hold counter, low for a fifth period
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hold_q     <= '0;
			hold_end_q <= 1'b0;
		end
		else if (!enable_lvl)
		begin
			// disabled: fault pin floats
			hold_q     <= '0;
			hold_end_q <= 1'b0;
		end
		else if (fault_evt)
		begin
			// load hold length, never zero
			hold_q     <= (hold_ticks == '0) ? WWD_CW'(1) : hold_ticks; // RULE_18
			hold_end_q <= 1'b0;
		end
		else if (tick && hold_q != '0)
		begin
			// count down; flag the release
			hold_q     <= hold_q - 1'b1;
			hold_end_q <= (hold_q == WWD_CW'(1));
		end
		else
			hold_end_q <= 1'b0;
	end

	// pin drive: open drain, pull low when enable set
	assign output_on_o          = out_on_q;
	assign supply_good_out_o    = good_q;
	assign supply_good_out_oe_o = !good_q;
	// fault pin value is low; only the enable toggles
	assign fault_out_n_o        = 1'b0;
	assign fault_out_n_oe_o     = enable_lvl && (hold_q != '0); // RULE_17 RULE_18 RULE_20
endmodule
`default_nettype wire

// >>> tb/wwd_props.sv
`default_nettype none
module wwd_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic vout_above_rise_i,
	input wire logic vout_below_fall_i,
	input wire logic input_undervoltage_lock_i,
	input wire logic thermal_trip_i,
	input wire logic guard_enable_n_i,
	input wire logic output_on_o,
	input wire logic supply_good_out_o,
	input wire logic supply_good_out_oe_o,
	input wire logic fault_out_n_o,
	input wire logic fault_out_n_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// good holds through the deglitch, then drops
	sequence glitch_s;
		supply_good_out_o [*3] ##[1:4] !supply_good_out_o;
	endsequence
	input_undervoltage_lock_off_a: assert property (input_undervoltage_lock_i |=> !output_on_o)
		else $error("output stayed on under lockout");
	trip_off_a: assert property (thermal_trip_i |=> !output_on_o)
		else $error("output stayed on under thermal trip");
	power_on_a: assert property (!input_undervoltage_lock_i && !thermal_trip_i |=> output_on_o)
		else $error("output not back on after fault cleared");
	restart_low_a: assert property ($rose(output_on_o) |-> !supply_good_out_o)
		else $error("good high at output restart");
	good_delay_a: assert property ($rose(supply_good_out_o) |-> $past(vout_above_rise_i, 16))
		else $error("good rose before the delay");
	good_fall_a: assert property (
		$rose(vout_below_fall_i) && output_on_o && supply_good_out_o |=> glitch_s)
		else $error("good fall timing wrong");
	good_pin_a: assert property (supply_good_out_oe_o == !supply_good_out_o)
		else $error("good pull-low not inverse of level");
	fault_off_a: assert property (!supply_good_out_o [*3] |-> !fault_out_n_oe_o)
		else $error("fault driven while good low");
	fault_arm_a: assert property (
		$rose(fault_out_n_oe_o) |-> supply_good_out_o && !guard_enable_n_i)
		else $error("fault raised while disabled");
	fault_pin_a: assert property (fault_out_n_oe_o |-> !fault_out_n_o)
		else $error("fault pin not pulled low");
endmodule
bind wwd_core wwd_props u_props (.clk_i, .rst_i, .vout_above_rise_i, .vout_below_fall_i,
	.input_undervoltage_lock_i, .thermal_trip_i, .guard_enable_n_i, .output_on_o,
	.supply_good_out_o, .supply_good_out_oe_o, .fault_out_n_o, .fault_out_n_oe_o);
`default_nettype wire

// >>> tb/wwd_mcu.sv
`default_nettype none
// controller model: service pulses and watchdog enable
module wwd_mcu (
	input  wire logic clk_i,
	output logic      service_o,
	output logic      enable_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		service_o = 1'b0;
		enable_n_o = 1'b1;
	end
	// low arms the watchdog, high disarms
	task arm(input logic en_n);
		@(posedge clk_i);
		#1 enable_n_o = en_n;
	endtask
	// pulse of four ticks, longer than the qualify time
	task svc;
		@(posedge clk_i);
		#1 service_o = 1'b1;
		repeat (16) @(posedge clk_i);
		#1 service_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/test_window_watchdog_supply_good.sv
`default_nettype none
module test_window_watchdog_supply_good;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_i, vup, vdown;
	logic delay_cap_present_i, input_undervoltage_lock_i;
	logic thermal_trip_i, type_select_pin_i;
	logic period_scale_select_i, ratio_select_i;
	logic [15:0] timing_resistor_pin_i; // resistor in hundreds of ohms
	logic service_in_i, guard_enable_n_i, output_on_o, supply_good_out_o;
	logic supply_good_out_oe_o, fault_out_n_o, fault_out_n_oe_o;
	int n_fail = 0, num_checks = 0;
	// output voltage model: valid only while output is on
	wire logic vout_above_rise_i = output_on_o & vup;
	wire logic vout_below_fall_i = ~output_on_o | vdown;
	always #4 clk_i = ~clk_i;
	wwd_core #(.DLY_FIX_CYC(20), .DLY_CAP_CYC(100), .DEGLITCH_CYC(4), .OSC_DIV(4),
		.SVC_MIN_TICKS(2)) uut (.clk_i, .rst_i, .vout_above_rise_i, .vout_below_fall_i,
		.delay_cap_present_i, .input_undervoltage_lock_i, .thermal_trip_i,
		.type_select_pin_i, .period_scale_select_i, .ratio_select_i,
		.timing_resistor_pin_i, .service_in_i, .guard_enable_n_i, .output_on_o,
		.supply_good_out_o, .supply_good_out_oe_o, .fault_out_n_o, .fault_out_n_oe_o);
	wwd_mcu mcu (.clk_i, .service_o(service_in_i), .enable_n_o(guard_enable_n_i));
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task chk(input logic s, input logic e);
		num_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error at %0t ns: output mismatch", $time);
		end
	endtask
	// q quiet cycles, then a fault within w cycles lasting about h
	task fwait(input int q, input int w, input int h);
		int   i;
		logic f;
		f = 1'b0;
		for (i = 0; i < q; i++)
		begin
			step(1);
			f = f | fault_out_n_oe_o;
		end
		chk(f, 1'b0);
		if (w > 0)
		begin
			for (i = 0; i < w && f !== 1'b1; i++)
			begin
				step(1);
				f = fault_out_n_oe_o;
			end
			chk(f, 1'b1);
			chk(fault_out_n_o, 1'b0);
			for (i = 0; i < 400 && fault_out_n_oe_o === 1'b1; i++)
				step(1);
			chk(i > h - 6 && i < h + 6, 1'b1);
		end
	endtask
	task test_done;
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// hang guard, well past the expected run
	initial
	begin
		#400us;
		n_fail++;
		test_done();
	end
	initial
	begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		vup = 1'b0;
		vdown = 1'b0;
		delay_cap_present_i = 1'b0;
		input_undervoltage_lock_i = 1'b0;
		thermal_trip_i = 1'b0;
		type_select_pin_i = 1'b0;
		period_scale_select_i = 1'b0;
		ratio_select_i = 1'b0;
		timing_resistor_pin_i = 16'h0001; // 50 ticks a period
		step(5);
		chk(output_on_o, 1'b0);
		chk(supply_good_out_oe_o, 1'b1);
		rst_i = 1'b0;
		step(1);
		chk(output_on_o, 1'b1);
		vup = 1'b1;
		step(15);
		chk(supply_good_out_o, 1'b0);
		step(15);
		chk(supply_good_out_o, 1'b1);
		vdown = 1'b1;
		step(2);
		chk(supply_good_out_o, 1'b1);
		step(8);
		chk(supply_good_out_o, 1'b0);
		vup = 1'b0;
		step(2);
		vdown = 1'b0;
		vup = 1'b1;
		delay_cap_present_i = 1'b1;
		step(80);
		chk(supply_good_out_o, 1'b0);
		step(30);
		chk(supply_good_out_o, 1'b1);
		period_scale_select_i = 1'b1;
		mcu.arm(1'b0);
		fwait(7900, 300, 200);
		mcu.arm(1'b1);
		period_scale_select_i = 1'b0;
		mcu.arm(1'b0);
		fwait(400, 0, 0);
		mcu.svc();
		fwait(20, 0, 0);
		mcu.svc();
		fwait(0, 30, 36);
		mcu.svc();
		fwait(130, 0, 0);
		mcu.svc();
		fwait(170, 60, 40);
		mcu.arm(1'b1);
		ratio_select_i = 1'b1;
		mcu.arm(1'b0);
		mcu.svc();
		fwait(30, 0, 0);
		mcu.svc();
		fwait(150, 60, 40);
		mcu.arm(1'b1);
		ratio_select_i = 1'b0;
		type_select_pin_i = 1'b1;
		mcu.arm(1'b0);
		mcu.svc();
		fwait(20, 0, 0);
		mcu.svc();
		fwait(20, 0, 0);
		mcu.arm(1'b1);
		fwait(400, 0, 0);
		type_select_pin_i = 1'b0;
		mcu.arm(1'b0);
		input_undervoltage_lock_i = 1'b1;
		step(2);
		chk(output_on_o, 1'b0);
		step(8);
		chk(supply_good_out_o, 1'b0);
		fwait(1700, 0, 0);
		input_undervoltage_lock_i = 1'b0;
		step(2);
		chk(output_on_o, 1'b1);
		step(10);
		chk(supply_good_out_o, 1'b0);
		step(100);
		chk(supply_good_out_o, 1'b1);
		thermal_trip_i = 1'b1;
		step(2);
		chk(output_on_o, 1'b0);
		thermal_trip_i = 1'b0;
		step(2);
		chk(output_on_o, 1'b1);
		// doubled resistor doubles every window
		timing_resistor_pin_i = 16'h0002;
		step(120);
		chk(supply_good_out_o, 1'b1);
		mcu.svc();
		fwait(370, 40, 80);
		test_done();
	end
endmodule
`default_nettype wire
